//--- common/tlb_pkg.sv
// shared types and constants for the traffic-channel test loop block
package tlb_pkg;
    localparam int FRAME_BITS  = 260;  // full and half rate frame
    localparam int EFR_BITS    = 244;  // enhanced full rate frame
    localparam int BURST_BITS  = 114;  // burst payload, no flags
    localparam int REPORT_FRMS = 104;  // one reporting period
    localparam int RTD_LIMIT   = 26;   // round trip bound, frames
    localparam int RTD_DEFAULT = 8;    // declared round trip delay
    localparam int LINE_DEPTH  = 32;   // burst slots in delay line
    localparam int CHAN_W      = 3;
    localparam int STAMP_W     = 8;
    localparam int CNT_W       = 8;
    localparam logic [2:0] TEST_SAPI = 3'h0;
    localparam logic [FRAME_BITS-1:0] EFR_MASK =
        {{(FRAME_BITS-EFR_BITS){1'b0}}, {EFR_BITS{1'b1}}};

    typedef logic [CHAN_W-1:0] tlb_chan_t;
    typedef enum logic [1:0] {LOOP_A, LOOP_B, LOOP_C} tlb_loop_e;
    typedef enum logic [1:0] {RATE_FULL, RATE_HALF, RATE_EFR} tlb_rate_e;
    typedef enum logic [1:0] {OP_CLOSE, OP_OPEN, OP_OTHER} tlb_op_e;
    typedef enum logic [1:0] {BK_TCH, BK_SACCH, BK_IDLE} tlb_bkind_e;

    // decoded layer 3 test command
    typedef struct packed {
        logic      valid;
        logic [2:0] sapi;
        logic      ack_mode;
        tlb_op_e   op;
        tlb_loop_e loop;
        tlb_chan_t chan;
    } tlb_cmd_s;

    // close acknowledge towards layer 3
    typedef struct packed {
        logic      valid;
        tlb_chan_t chan;
    } tlb_ack_s;

    // decoded frame, both directions
    typedef struct packed {
        logic                  valid;
        tlb_chan_t             chan;
        tlb_rate_e             rate;
        logic                  speech;
        logic                  bad;
        logic                  facch;
        logic [FRAME_BITS-1:0] data;
    } tlb_frame_s;

    // received burst after decryption
    typedef struct packed {
        logic                  valid;
        tlb_bkind_e            kind;
        logic [BURST_BITS-1:0] data;
    } tlb_burst_s;

    // uplink burst request
    typedef struct packed {
        logic                  valid;
        logic                  own_midamble;
        logic [BURST_BITS-1:0] data;
    } tlb_ul_burst_s;
endpackage : tlb_pkg

//--- hw/tlb_burst_line.sv
// delay line for the burst-by-burst loop
`timescale 1ns/100ps
module tlb_burst_line #(
    parameter int DEPTH = tlb_pkg::LINE_DEPTH,
    parameter int RTD   = tlb_pkg::RTD_DEFAULT
) (
    input  wire logic                           clk_i,
    input  wire logic                           rst_n_i,
    input  wire logic                           flush_i,
    input  wire logic                           tick_i,
    input  wire logic                           ul_traffic_i,
    input  wire logic                           push_i,
    input  wire logic [tlb_pkg::BURST_BITS-1:0] data_i,
    output tlb_pkg::tlb_ul_burst_s              out_o
);
    import tlb_pkg::*;
    localparam int PW = $clog2(DEPTH);
    localparam logic [STAMP_W-1:0] RTD_W = STAMP_W'(RTD);

    logic [BURST_BITS-1:0] mem_q [DEPTH];
    logic [STAMP_W-1:0]    stamp_q [DEPTH];
    logic [PW-1:0]         wr_q, rd_q;
    logic [PW:0]           cnt_q;
    logic [STAMP_W-1:0]    fcnt_q;
    logic                  pop, push;
    tlb_ul_burst_s         out_q;

    // frames a burst has waited, wraps safely below 256
    function automatic logic [STAMP_W-1:0] age(
        input logic [STAMP_W-1:0] now, input logic [STAMP_W-1:0] st);
        age = now - st;
    endfunction : age

    // uplink sacch slot holds the head back one more frame;
    // age counts the frame this tick opens, so delay is exactly rtd
    assign pop  = tick_i && ul_traffic_i && cnt_q != '0 &&
                  age(fcnt_q + 1'b1, stamp_q[rd_q]) >= RTD_W;
    assign push = push_i && cnt_q != (PW+1)'(DEPTH);
    assign out_o = out_q;

    // frame counter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) fcnt_q <= '0;
        else if (tick_i) fcnt_q <= fcnt_q + 1'b1;
    end

    // storage, no reset needed on data
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q]   <= data_i;
            stamp_q[wr_q] <= fcnt_q;
        end
    end

    // pointers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (flush_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // uplink burst always carries our own midamble
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_q <= '0;
        end else begin
            out_q.valid        <= pop && !flush_i;
            out_q.own_midamble <= 1'b1;
            if (pop) out_q.data <= mem_q[rd_q];
        end
    end

    no_early_pop_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        pop |=> age(fcnt_q, $past(stamp_q[rd_q])) >= RTD_W)
        else $error("burst left before its round trip delay");
    sacch_slot_kept_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        (tick_i && !ul_traffic_i) |=> !out_q.valid)
        else $error("burst sent in uplink control frame");
endmodule : tlb_burst_line

//--- hw/tlb_loop_ctrl.sv
// traffic-channel test loop controller, top level
// Contract
// - commands arrive as layer 3 on control channel, sapi 0, acknowledged
// - power-off or test card removal deactivates every test function
// - traffic loop and audio interface test never active together
// - close ignored silently without traffic channel or with loop closed
// - with traffic channel, close named channel loop and acknowledge
// - loop a returns good speech and data frames decoder to encoder
// - loops a and b return 260 bits on full/half rate
// - loops a and b return 244 bits on enhanced full rate
// - loop a sends all-zero frame for bad speech frame
// - loop a leaves stolen frame traffic undefined, control runs normal
// - loop b returns every speech frame, no erasure signalling; code drops speech frames stolen for facch
// - loop c returns 114 burst bits after decryption, before decoding
// - loop c returns every burst, own midamble on uplink
// - loop c does not loop control or idle bursts
// - loop c running within 104 frames after acknowledge
// - loop c round trip below 26 frames, value declared
// - uplink control frame keeps place, later bursts delayed one more
// - burst-by-burst loop always implemented
`timescale 1ns/100ps
module tlb_loop_ctrl #(
    parameter int RTD = tlb_pkg::RTD_DEFAULT
) (
    input  wire logic                CLK_SYS_I,
    input  wire logic                RSTN_I,
    input  tlb_pkg::tlb_cmd_s        CMD_I,
    input  wire logic                TCH_ACTIVE_I,
    input  wire logic                DAI_REQ_I,
    input  wire logic                DAI_STOP_I,
    input  wire logic                POWER_OFF_I,
    input  wire logic                TEST_SIM_I,
    input  wire logic                FRAME_TICK_I,
    input  wire logic                UL_TRAFFIC_I,
    input  tlb_pkg::tlb_frame_s      DL_FRAME_I,
    input  tlb_pkg::tlb_burst_s      DL_BURST_I,
    output tlb_pkg::tlb_ack_s        ACK_O,
    output logic                     LOOP_CLOSED_O,
    output tlb_pkg::tlb_loop_e       LOOP_TYPE_O,
    output tlb_pkg::tlb_chan_t       LOOP_CHAN_O,
    output logic                     LOOP_C_LIVE_O,
    output logic                     DAI_ACTIVE_O,
    output tlb_pkg::tlb_frame_s      UL_FRAME_O,
    output tlb_pkg::tlb_ul_burst_s   UL_BURST_O
);
    import tlb_pkg::*;

    typedef enum logic [1:0] {ST_OPEN, ST_LOOP, ST_DAI} tlb_state_e;

    localparam logic [CNT_W-1:0] REPORT_W = CNT_W'(REPORT_FRMS);

    tlb_state_e  state_q;
    tlb_loop_e   loop_q;
    tlb_chan_t   chan_q;
    tlb_ack_s    ack_q;
    tlb_frame_s  ul_frame_q;
    logic        c_live_q;
    logic        c_wait_q;
    logic [CNT_W-1:0] wait_cnt_q;

    logic        kill;
    logic        close_req;
    logic        open_req;
    logic        close_ok;
    logic        frame_hit;
    logic        frame_send;
    logic        frame_zero;
    logic        burst_push;

    // only test commands on sapi 0 in acknowledged mode count
    function automatic logic cmd_ok(input tlb_cmd_s c);
        cmd_ok = c.valid && c.sapi == TEST_SAPI && c.ack_mode;
    endfunction : cmd_ok

    // frame width kept for the channel rate
    function automatic logic [FRAME_BITS-1:0] rate_mask(
        input tlb_rate_e r);
        rate_mask = (r == RATE_EFR) ? EFR_MASK : '1;
    endfunction : rate_mask

    // deactivation sources outside the command path
    assign kill = POWER_OFF_I || !TEST_SIM_I;

    // command decode
    assign close_req = cmd_ok(CMD_I) && CMD_I.op == OP_CLOSE;
    assign open_req  = cmd_ok(CMD_I) && CMD_I.op == OP_OPEN;

    // close only from the open state with a live traffic channel;
    // dai state also blocks it, keeping the tests exclusive
    assign close_ok = close_req && !kill && TCH_ACTIVE_I &&
                      state_q == ST_OPEN;

    // control state machine
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_q <= ST_OPEN;
        end else begin
            case (state_q)
                ST_OPEN: begin
                    if (close_ok) begin
                        state_q <= ST_LOOP;
                    end else if (DAI_REQ_I && !kill) begin
                        state_q <= ST_DAI;
                    end
                end
                ST_LOOP: begin
                    if (kill || open_req) begin
                        state_q <= ST_OPEN;
                    end
                end
                ST_DAI: begin
                    if (kill || DAI_STOP_I) begin
                        state_q <= ST_OPEN;
                    end
                end
                default: begin
                    state_q <= ST_OPEN;
                end
            endcase
        end
    end

    // selected loop and channel, captured on acceptance
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            loop_q <= LOOP_A;
            chan_q <= '0;
        end else if (close_ok) begin
            loop_q <= CMD_I.loop;
            chan_q <= CMD_I.chan;
        end
    end

    // acknowledge pulse; refused commands get no answer at all
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ack_q <= '0;
        end else begin
            ack_q.valid <= close_ok;
            if (close_ok) ack_q.chan <= CMD_I.chan;
        end
    end

    // loop c goes live on the first frame tick after the ack;
    // waiting keeps the line aligned to frame boundaries
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            c_wait_q <= 1'b0;
            c_live_q <= 1'b0;
        end else if (state_q != ST_LOOP || open_req || kill) begin
            c_wait_q <= 1'b0;
            c_live_q <= 1'b0;
        end else if (ack_q.valid && loop_q == LOOP_C) begin
            c_wait_q <= 1'b1;
        end else if (c_wait_q && FRAME_TICK_I) begin
            c_wait_q <= 1'b0;
            c_live_q <= 1'b1;
        end
    end

    // frames since ack while loop c is pending
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wait_cnt_q <= '0;
        end else if (!c_wait_q) begin
            wait_cnt_q <= '0;
        end else if (FRAME_TICK_I && wait_cnt_q != '1) begin
            wait_cnt_q <= wait_cnt_q + 1'b1;
        end
    end

    // frame loop selection for loops a and b
    assign frame_hit = state_q == ST_LOOP && loop_q != LOOP_C &&
                       DL_FRAME_I.valid && DL_FRAME_I.chan == chan_q;

    // loop a: good speech and data pass, stolen frames send nothing;
    // loop b: every speech frame not stolen for facch passes, bad or not
    always_comb begin
        frame_send = 1'b0;
        frame_zero = 1'b0;
        if (loop_q == LOOP_A) begin
            frame_send = !DL_FRAME_I.facch;
            frame_zero = DL_FRAME_I.speech && DL_FRAME_I.bad;
        end else begin
            frame_send = DL_FRAME_I.speech && !DL_FRAME_I.facch;
        end
    end

    // uplink frame to the channel encoder
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ul_frame_q <= '0;
        end else begin
            ul_frame_q.valid <= frame_hit && frame_send;
            if (frame_hit) begin
                ul_frame_q.chan   <= DL_FRAME_I.chan;
                ul_frame_q.rate   <= DL_FRAME_I.rate;
                ul_frame_q.speech <= DL_FRAME_I.speech;
                ul_frame_q.bad    <= 1'b0;
                ul_frame_q.facch  <= 1'b0;
                ul_frame_q.data   <= frame_zero ? '0 :
                    DL_FRAME_I.data & rate_mask(DL_FRAME_I.rate);
            end
        end
    end

    // only traffic bursts enter the loop, midamble state ignored
    assign burst_push = c_live_q && DL_BURST_I.valid &&
                        DL_BURST_I.kind == BK_TCH;

    // burst-by-burst loop, present in every build
    tlb_burst_line #(
        .DEPTH (LINE_DEPTH),
        .RTD   (RTD)
    ) u_line (
        .clk_i        (CLK_SYS_I),
        .rst_n_i      (RSTN_I),
        .flush_i      (!c_live_q),
        .tick_i       (FRAME_TICK_I),
        .ul_traffic_i (UL_TRAFFIC_I),
        .push_i       (burst_push),
        .data_i       (DL_BURST_I.data),
        .out_o        (UL_BURST_O)
    );

    // outputs
    assign ACK_O         = ack_q;
    assign LOOP_CLOSED_O = state_q == ST_LOOP;
    assign LOOP_TYPE_O   = loop_q;
    assign LOOP_CHAN_O   = chan_q;
    assign LOOP_C_LIVE_O = c_live_q;
    assign DAI_ACTIVE_O  = state_q == ST_DAI;
    assign UL_FRAME_O    = ul_frame_q;

    // checks
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RSTN_I);

    sequence close_accepted;
        close_ok ##1 ack_q.valid;
    endsequence

    sequence closed_for_two;
        LOOP_CLOSED_O [*2];
    endsequence

    wrong_sapi_a: assert property (
        (CMD_I.valid && CMD_I.sapi != TEST_SAPI) |=> !ack_q.valid)
        else $error("command on wrong sapi was acknowledged");

    sim_removal_a: assert property (
        (kill && state_q != ST_OPEN) |=> state_q == ST_OPEN)
        else $error("test function survived deactivation");

    exclusive_tests_a: assert property (
        !(LOOP_CLOSED_O && DAI_ACTIVE_O))
        else $error("loop and audio test active together");

    no_double_close_a: assert property (
        (close_req && LOOP_CLOSED_O) |=> !ack_q.valid)
        else $error("close acknowledged with loop already closed");

    // a loop already closed stays closed unless a kill source is set; no ack either
    no_tch_close_a: assert property (
        (close_req && !TCH_ACTIVE_I) |=> !ack_q.valid &&
        LOOP_CLOSED_O == $past(LOOP_CLOSED_O && !kill))
        else $error("close accepted without traffic channel");

    ack_follows_a: assert property (
        close_accepted |-> ack_q.chan == $past(CMD_I.chan) &&
        LOOP_CLOSED_O && chan_q == ack_q.chan)
        else $error("acknowledge does not match accepted close");

    single_ack_a: assert property (
        close_accepted ##0 (!open_req && !kill) |=> !ack_q.valid)
        else $error("acknowledge longer than one cycle");

    bad_frame_zero_a: assert property (
        (frame_hit && loop_q == LOOP_A && DL_FRAME_I.speech &&
         DL_FRAME_I.bad && !DL_FRAME_I.facch)
        |=> ul_frame_q.valid && ul_frame_q.data == '0)
        else $error("bad frame not sent as zeros in loop a");

    loop_b_pass_a: assert property (
        (frame_hit && loop_q == LOOP_B && DL_FRAME_I.speech &&
         !DL_FRAME_I.facch)
        |=> ul_frame_q.valid && ul_frame_q.data ==
            ($past(DL_FRAME_I.data) & rate_mask($past(DL_FRAME_I.rate))))
        else $error("loop b frame altered or dropped");

    efr_width_a: assert property (
        ul_frame_q.valid && ul_frame_q.rate == RATE_EFR |->
        (ul_frame_q.data & ~EFR_MASK) == '0)
        else $error("enhanced rate frame wider than its payload");

    facch_loop_a_a: assert property (
        (frame_hit && loop_q == LOOP_A && DL_FRAME_I.facch)
        |=> !ul_frame_q.valid)
        else $error("stolen frame looped in loop a");

    loop_c_start_a: assert property (
        c_wait_q |-> wait_cnt_q < REPORT_W)
        else $error("loop c not live within reporting period");

    loop_c_idle_a: assert property (
        (closed_for_two ##0 loop_q != LOOP_C) |-> !c_live_q)
        else $error("burst loop live for frame loop type");

    no_sacch_push_a: assert property (
        (DL_BURST_I.valid && DL_BURST_I.kind != BK_TCH) |-> !burst_push)
        else $error("control or idle burst entered the loop");

    rtd_declared_a: assert property (
        RTD < RTD_LIMIT && RTD >= 1)
        else $error("declared round trip delay out of range");
endmodule : tlb_loop_ctrl

//--- test/tch_test_loopback_tb_top.sv
// self-checking bench for the traffic-channel test loop controller
`timescale 1ns/100ps
module tch_test_loopback_tb_top;
    import tlb_pkg::*;
    localparam int RTD = 8;
    localparam int TICK_CYC = 6;
    localparam logic [FRAME_BITS-1:0] PAT = {65{4'hA}};
    localparam logic [FRAME_BITS-1:0] PAT_EFR = {16'h0000, {61{4'hA}}};
    logic clk = 1'b0;
    logic rst_n, tch, dai_req, dai_stop, pwr_off, sim, close_sent;
    logic closed, live, dai_act, tick, traf, tt01;
    logic [15:0] fno;
    tlb_cmd_s cmd;
    tlb_frame_s dlf, ulf;
    tlb_burst_s dlb;
    tlb_ack_s ack;
    tlb_ul_burst_s ulb;
    tlb_loop_e ltype;
    tlb_chan_t lchan;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [BURST_BITS-1:0] dat_q[$];
    logic [15:0] frm_q[$];

    always #12.5 clk = ~clk;

    tlb_loop_ctrl #(.RTD(RTD)) i_dut (
        .CLK_SYS_I(clk), .RSTN_I(rst_n), .CMD_I(cmd), .TCH_ACTIVE_I(tch),
        .DAI_REQ_I(dai_req), .DAI_STOP_I(dai_stop), .POWER_OFF_I(pwr_off),
        .TEST_SIM_I(sim), .FRAME_TICK_I(tick), .UL_TRAFFIC_I(traf),
        .DL_FRAME_I(dlf), .DL_BURST_I(dlb), .ACK_O(ack),
        .LOOP_CLOSED_O(closed), .LOOP_TYPE_O(ltype), .LOOP_CHAN_O(lchan),
        .LOOP_C_LIVE_O(live), .DAI_ACTIVE_O(dai_act), .UL_FRAME_O(ulf),
        .UL_BURST_O(ulb));

    tlb_sim_model #(.TICK_CYC(TICK_CYC)) i_sim (
        .clk_i(clk), .rst_n_i(rst_n), .close_sent_i(close_sent),
        .ack_i(ack.valid), .tick_o(tick), .traffic_o(traf),
        .frame_no_o(fno), .tt01_run_o(tt01));

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_dat(input string nm, input logic [FRAME_BITS-1:0] e,
                           input logic [FRAME_BITS-1:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk_dat

    // one command pulse; ack must follow exactly one cycle later
    task automatic cmd_t(input tlb_op_e op, input tlb_loop_e lp,
                         input tlb_chan_t ch, input logic [2:0] sp,
                         input logic am, input logic ev);
        @(posedge clk);
        cmd <= '{1'b1, sp, am, op, lp, ch};
        close_sent <= (op == OP_CLOSE);
        @(posedge clk);
        cmd.valid <= 1'b0;
        close_sent <= 1'b0;
        #1;
        chk_bit("ack valid", ev, ack.valid);
        if (ev) begin
            chk_bit("timer running", 1'b1, tt01);
            chk_dat("ack chan", FRAME_BITS'(ch),
                    FRAME_BITS'(ack.chan));
            chk_bit("closed with ack", 1'b1, closed);
        end
        repeat (2) @(posedge clk);
    endtask : cmd_t

    // one downlink frame; uplink copy expected one cycle later or never
    task automatic frm_t(input tlb_chan_t ch, input tlb_rate_e rt,
                         input logic sp, input logic bd, input logic fa,
                         input logic ev, input logic [FRAME_BITS-1:0] ed);
        @(posedge clk);
        dlf <= '{1'b1, ch, rt, sp, bd, fa, PAT};
        @(posedge clk);
        dlf.valid <= 1'b0;
        #1;
        chk_bit("ul frame valid", ev, ulf.valid);
        if (ev) chk_dat("ul frame data", ed, ulf.data);
    endtask : frm_t

    task automatic t_loop_a();
        tch <= 1'b0;
        cmd_t(OP_CLOSE, LOOP_A, 3'h2, 3'h0, 1'b1, 1'b0);
        tch <= 1'b1;
        cmd_t(OP_CLOSE, LOOP_A, 3'h2, 3'h1, 1'b1, 1'b0);
        cmd_t(OP_CLOSE, LOOP_A, 3'h2, 3'h0, 1'b0, 1'b0);
        cmd_t(OP_CLOSE, LOOP_A, 3'h2, 3'h0, 1'b1, 1'b1);
        chk_bit("loop type a", 1'b1, ltype === LOOP_A);
        chk_dat("loop chan", FRAME_BITS'(3'h2), FRAME_BITS'(lchan));
        chk_bit("timer stopped", 1'b0, tt01);
        cmd_t(OP_CLOSE, LOOP_B, 3'h3, 3'h0, 1'b1, 1'b0);
        frm_t(3'h2, RATE_FULL, 1'b1, 1'b0, 1'b0, 1'b1, PAT);
        frm_t(3'h2, RATE_HALF, 1'b0, 1'b0, 1'b0, 1'b1, PAT);
        frm_t(3'h2, RATE_EFR, 1'b1, 1'b0, 1'b0, 1'b1, PAT_EFR);
        frm_t(3'h2, RATE_FULL, 1'b1, 1'b1, 1'b0, 1'b1, '0);
        frm_t(3'h2, RATE_FULL, 1'b1, 1'b0, 1'b1, 1'b0, '0);
        frm_t(3'h3, RATE_FULL, 1'b1, 1'b0, 1'b0, 1'b0, '0);
        cmd_t(OP_OPEN, LOOP_A, 3'h2, 3'h0, 1'b1, 1'b0);
        chk_bit("opened", 1'b0, closed);
        $display("test loop_a done, mismatches %0d", err_count);
    endtask : t_loop_a

    // bad speech frames pass unchanged, data frames are dropped; card removal opens the loop
    task automatic t_loop_b();
        cmd_t(OP_CLOSE, LOOP_B, 3'h1, 3'h0, 1'b1, 1'b1);
        frm_t(3'h1, RATE_FULL, 1'b1, 1'b1, 1'b0, 1'b1, PAT);
        frm_t(3'h1, RATE_FULL, 1'b0, 1'b0, 1'b0, 1'b0, '0);
        frm_t(3'h1, RATE_EFR, 1'b1, 1'b0, 1'b0, 1'b1, PAT_EFR);
        sim <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk_bit("closed after card out", 1'b0, closed);
        sim <= 1'b1;
        $display("test loop_b done, mismatches %0d", err_count);
    endtask : t_loop_b

    task automatic t_dai();
        @(posedge clk);
        dai_req <= 1'b1;
        @(posedge clk);
        dai_req <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk_bit("audio test on", 1'b1, dai_act);
        cmd_t(OP_CLOSE, LOOP_A, 3'h0, 3'h0, 1'b1, 1'b0);
        @(posedge clk);
        dai_stop <= 1'b1;
        @(posedge clk);
        dai_stop <= 1'b0;
        cmd_t(OP_CLOSE, LOOP_A, 3'h0, 3'h0, 1'b1, 1'b1);
        chk_bit("audio test off", 1'b0, dai_act);
        dai_req <= 1'b1;
        @(posedge clk);
        dai_req <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk_bit("audio test refused", 1'b0, dai_act);
        pwr_off <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk_bit("closed after power off", 1'b0, closed);
        pwr_off <= 1'b0;
        $display("test dai done, mismatches %0d", err_count);
    endtask : t_dai

    // bursts across the control frame; expected uplink frame computed ahead
    task automatic t_loop_c();
        int n;
        int e;
        int last_e;
        tlb_bkind_e kd;
        cmd_t(OP_CLOSE, LOOP_C, 3'h4, 3'h0, 1'b1, 1'b1);
        for (n = 0; n < REPORT_FRMS * TICK_CYC && live !== 1'b1; n++)
            @(posedge clk);
        chk_bit("loop c live", 1'b1, live);
        last_e = 0;
        for (int i = 0; i < 16; i++) begin
            kd = (i == 3) ? BK_SACCH : ((i == 9) ? BK_IDLE : BK_TCH);
            @(posedge clk iff tick);
            @(posedge clk);
            dlb <= '{1'b1, kd, {2'h0, {14{8'(i)}}}};
            if (kd == BK_TCH) begin
                e = int'(fno) + RTD;
                if (e <= last_e) e = last_e + 1;
                while ((e % 13) == 12) e++;
                last_e = e;
                dat_q.push_back({2'h0, {14{8'(i)}}});
                frm_q.push_back(16'(e));
            end
            @(posedge clk);
            dlb.valid <= 1'b0;
        end
        repeat ((RTD + 6) * TICK_CYC) @(posedge clk);
        chk_bit("bursts drained", 1'b1, dat_q.size() == 0);
        cmd_t(OP_OPEN, LOOP_C, 3'h4, 3'h0, 1'b1, 1'b0);
        chk_bit("loop c opened", 1'b0, closed);
        $display("test loop_c done, mismatches %0d", err_count);
    endtask : t_loop_c

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // uplink burst monitor against the expected queues
    always @(posedge clk) begin
        if (ulb.valid === 1'b1) begin
            if (dat_q.size() == 0) begin
                chk_bit("spare burst", 1'b0, 1'b1);
            end else begin
                chk_dat("burst data", FRAME_BITS'(dat_q.pop_front()),
                        FRAME_BITS'(ulb.data));
                chk_bit("own midamble", 1'b1, ulb.own_midamble);
                chk_dat("burst frame", FRAME_BITS'(frm_q.pop_front()),
                        FRAME_BITS'(fno));
            end
        end
    end

    // hang guard, well above the run length of all tests
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end

    initial begin
        rst_n = 1'b0;
        tch = 1'b0;
        dai_req = 1'b0;
        dai_stop = 1'b0;
        pwr_off = 1'b0;
        sim = 1'b1;
        close_sent = 1'b0;
        cmd = '0;
        dlf = '0;
        dlb = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk_bit("reset closed", 1'b0, closed);
        chk_bit("reset ack", 1'b0, ack.valid);
        t_loop_a();
        t_loop_b();
        t_dai();
        t_loop_c();
        results();
    end
endmodule : tch_test_loopback_tb_top

//--- test/tlb_sim_model.sv
// simulator side model: frame timing and close supervision timer
`timescale 1ns/100ps
module tlb_sim_model #(
    parameter int TICK_CYC = 6
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        close_sent_i,
    input  wire logic        ack_i,
    output logic             tick_o,
    output logic             traffic_o,
    output logic [15:0]      frame_no_o,
    output logic             tt01_run_o
);
    logic [7:0] div_q;

    // frame divider; frame 12 of every 13 is the uplink control slot
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q      <= 8'h00;
            tick_o     <= 1'b0;
            traffic_o  <= 1'b0;
            frame_no_o <= 16'h0000;
        end else if (div_q == 8'(TICK_CYC - 1)) begin
            div_q      <= 8'h00;
            tick_o     <= 1'b1;
            frame_no_o <= frame_no_o + 16'h0001;
            traffic_o  <= ((frame_no_o + 16'h0001) % 16'h000D)
                          != 16'h000C;
        end else begin
            div_q  <= div_q + 8'h01;
            tick_o <= 1'b0;
        end
    end

    // supervision timer runs from close sent until acknowledge seen
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tt01_run_o <= 1'b0;
        end else if (ack_i) begin
            tt01_run_o <= 1'b0;
        end else if (close_sent_i) begin
            tt01_run_o <= 1'b1;
        end
    end
endmodule : tlb_sim_model
